// ---- rtl/cqc_consts.vh ----
// Constants for the channel A C/Q control register block.
// Assumes inclusion by cqc_channel_ctrl.v only; cqc_pair_buf.v does not include it.
`ifndef CQC_CONSTS_VH
`define CQC_CONSTS_VH

`define CQC_ADDR_CTRL_A 8'h06
`define CQC_CTRL_RESET 8'h00
`define CQC_BIT_SEND 0
`define CQC_BIT_TMR_ARM 1
`define CQC_BIT_RXCLR 2
`define CQC_BIT_TXCLR 3
`define CQC_BIT_WAKE 4
`define CQC_BIT_EST 5
`define CQC_BIT_RATE_LO 6
`define CQC_BIT_RATE_HI 7
`define CQC_RATE_FAIL 2'h0
`define CQC_RATE_COM1 2'h1
`define CQC_RATE_COM2 2'h2
`define CQC_RATE_COM3 2'h3
// Wake-up pulse 80 us, reply wait 5 ms per rate try
`define CQC_WAKE_NS 80000
`define CQC_CLK_NS 10
`define CQC_WAIT_NS 5000000
`define CQC_BYTE_CYC 16'h0004

`endif

// ---- rtl/cqc_pair_buf.v ----
// Two-entry skid buffer with valid and ready on both sides.
// Assumes one clock, synchronous reset and a shared clock enable.
`timescale 1ns/1ps
module cqc_pair_buf #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire flush,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
reg [WIDTH-1:0] slot0_ff;
reg [WIDTH-1:0] slot1_ff;
reg [1:0] count_ff;
wire push;
wire pop;

assign in_ready = (count_ff != 2'd2);
assign out_valid = (count_ff != 2'd0);
assign out_data = slot0_ff;
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

////////////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk) begin
  if (reset || (clk_en && flush)) begin
    count_ff <= 2'd0;
    slot0_ff <= {WIDTH{1'b0}};
    slot1_ff <= {WIDTH{1'b0}};
  end else if (clk_en) begin
    if (push && !pop) begin
      count_ff <= count_ff + 2'd1;
      if (count_ff == 2'd0)
        slot0_ff <= in_data;
      else
        slot1_ff <= in_data;
    end else if (pop && !push) begin
      count_ff <= count_ff - 2'd1;
      slot0_ff <= slot1_ff;
    end else if (pop && push) begin
      // Full count never pops and pushes together, in_ready is low
      if (count_ff == 2'd1)
        slot0_ff <= in_data;
      else begin
        slot0_ff <= slot1_ff;
        slot1_ff <= in_data;
      end
    end
  end
end
endmodule // cqc_pair_buf

// ---- rtl/cqc_channel_ctrl.v ----
// Channel A C/Q control register and its sequencer: wake-up, establish
// communication, send, turnaround, queue clears and cycle timer arming.
// Assumes a byte register port, a transmit queue outside, a UART outside
// and an asynchronous pin for the device reply start bit, synchronised here.
//
// How it works
// - Writing 1 to the establish bit with frame_handler_enable high starts the full wake and rate search.
// - Success raises the wake-sequence interrupt pulse and clears the establish bit.
// - During the wake pulse the current limit is boosted; software setting untouched.
// - Success stores the found rate; cycle time is published to its register.
// - Failure also pulses the interrupt, clears establish and writes rate zero.
// - Writing 1 to the wake bit while idle drives a wake pulse at once; a write during a rate search is dropped.
// - After the wake pulse the line goes to receive and the wake bit clears.
// - Transmit queue clear bit empties the transmit queue.
// - Receive queue clear bit empties the receive queue.
// - Cycle timer arm bit only arms the timer, never starts it.
// - Armed timer starts on send bit or on a trigger command.
// - Clearing the arm bit stops the timer at once.
// - Send bit turns the line to transmit and sends the queued message.
// - When message done and queue empty the line turns to receive.
// - Send bit clears itself once the command is accepted.
// - Rate code: 00 failure, 01 4.8k, 10 38.4k, 11 230.4k.
`timescale 1ns/1ps
`include "cqc_consts.vh"
module cqc_channel_ctrl #(
  parameter WAKE_NS = `CQC_WAKE_NS,
  parameter WAIT_CYC = `CQC_WAIT_NS / `CQC_CLK_NS,
  parameter CYC_W = 16
) (
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire frame_handler_enable,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  input wire tx_queue_empty,
  input wire tx_byte_done,
  output reg [7:0] uart_data,
  output reg uart_valid,
  input wire uart_ready,
  input wire line_rx_pin,
  input wire trigger_cmd,
  input wire [7:0] device_cycle_time_in,
  output reg [7:0] device_cycle_time,
  output reg line_port_a_tx_en,
  output reg line_port_a_wake_drive,
  output reg current_limit_boost,
  output reg [1:0] line_rate,
  output reg tx_queue_clear,
  output reg rx_queue_clear,
  output reg wake_sequence_irq,
  output reg cycle_timer_run
);

localparam [31:0] WAKE_CYC_RAW = WAKE_NS / `CQC_CLK_NS;
localparam [CYC_W-1:0] WAKE_CYC = WAKE_CYC_RAW[CYC_W-1:0];
localparam [31:0] WAIT_CYC_W = WAIT_CYC;

localparam [2:0] ST_IDLE = 3'd0;
localparam [2:0] ST_WAKE = 3'd1;
localparam [2:0] ST_PROBE = 3'd2;
localparam [2:0] ST_LISTEN = 3'd3;
localparam [2:0] ST_SEND = 3'd4;
localparam [2:0] ST_DRAIN = 3'd5;
localparam [2:0] ST_RECV = 3'd6;

reg [2:0] state_ff;
reg [2:0] nxt_state;
reg est_ff;
reg wake_ff;
reg arm_ff;
reg send_ff;
reg from_est_ff;
reg [1:0] try_rate_ff;
reg [31:0] wait_ff;
reg [CYC_W-1:0] wake_cnt_ff;
reg rx_meta_ff;
reg rx_sync_ff;
reg rx_seen_ff;
wire ctrl_wr;
wire buf_valid;
wire [7:0] buf_data;
wire buf_take;
wire reply_seen;

assign ctrl_wr = reg_wr && (reg_addr == `CQC_ADDR_CTRL_A);
assign buf_take = (state_ff == ST_SEND) && uart_ready;
// Start bit of a reply pulls the line low
assign reply_seen = rx_seen_ff && !rx_sync_ff;

////////////////////////////////////////////////////////////////////////////////
// Stall at the UART holds the word, none lost
cqc_pair_buf #(
  .WIDTH(8)
) u_tx_buf (
  .ref_clk(ref_clk),
  .reset(reset),
  .clk_en(clk_en),
  .flush(tx_queue_clear),
  .in_data(tx_data),
  .in_valid(tx_valid),
  .in_ready(tx_ready),
  .out_data(buf_data),
  .out_valid(buf_valid),
  .out_ready(buf_take)
);

////////////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk) begin
  if (reset) begin
    rx_meta_ff <= 1'b1;
    rx_sync_ff <= 1'b1;
    rx_seen_ff <= 1'b1;
  end else if (clk_en) begin
    rx_meta_ff <= line_rx_pin;
    rx_sync_ff <= rx_meta_ff;
    rx_seen_ff <= rx_sync_ff;
  end
end

////////////////////////////////////////////////////////////////////////////////
always @* begin
  nxt_state = state_ff;
  case (state_ff)
    ST_IDLE: begin
      if (est_ff || wake_ff)
        nxt_state = ST_WAKE;
      else if (send_ff)
        nxt_state = ST_SEND;
    end
    ST_WAKE: begin
      if (wake_cnt_ff == {CYC_W{1'b0}})
        nxt_state = from_est_ff ? ST_PROBE : ST_RECV;
    end
    ST_PROBE: nxt_state = ST_LISTEN;
    ST_LISTEN: begin
      // Next rate is probed straight away; a pass through idle would restart the search
      if (reply_seen || (wait_ff == 32'd0 && try_rate_ff == `CQC_RATE_COM1))
        nxt_state = ST_IDLE;
      else if (wait_ff == 32'd0)
        nxt_state = ST_PROBE;
    end
    ST_SEND: begin
      if (!buf_valid && tx_queue_empty)
        nxt_state = ST_DRAIN;
    end
    ST_DRAIN: begin
      if (tx_byte_done)
        nxt_state = ST_RECV;
    end
    ST_RECV: nxt_state = ST_IDLE;
    default: nxt_state = ST_IDLE;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk) begin
  if (reset) begin
    state_ff <= ST_IDLE;
    est_ff <= 1'b0;
    wake_ff <= 1'b0;
    arm_ff <= 1'b0;
    send_ff <= 1'b0;
    from_est_ff <= 1'b0;
    try_rate_ff <= `CQC_RATE_COM3;
    wait_ff <= 32'd0;
    wake_cnt_ff <= {CYC_W{1'b0}};
    line_rate <= `CQC_RATE_FAIL;
    tx_queue_clear <= 1'b0;
    rx_queue_clear <= 1'b0;
    wake_sequence_irq <= 1'b0;
    cycle_timer_run <= 1'b0;
    line_port_a_tx_en <= 1'b0;
    line_port_a_wake_drive <= 1'b0;
    current_limit_boost <= 1'b0;
    uart_data <= 8'h00;
    uart_valid <= 1'b0;
    device_cycle_time <= 8'h00;
    reg_rdata <= 8'h00;
  end else if (clk_en) begin
    state_ff <= nxt_state;
    tx_queue_clear <= ctrl_wr && reg_wdata[`CQC_BIT_TXCLR];
    rx_queue_clear <= ctrl_wr && reg_wdata[`CQC_BIT_RXCLR];
    wake_sequence_irq <= 1'b0;
    uart_valid <= buf_take && buf_valid;
    if (buf_take && buf_valid)
      uart_data <= buf_data;
    if (ctrl_wr) begin
      arm_ff <= reg_wdata[`CQC_BIT_TMR_ARM];
      line_rate <= {reg_wdata[`CQC_BIT_RATE_HI], reg_wdata[`CQC_BIT_RATE_LO]};
      if (reg_wdata[`CQC_BIT_EST] && frame_handler_enable)
        est_ff <= 1'b1;
      if (reg_wdata[`CQC_BIT_WAKE])
        wake_ff <= 1'b1;
      if (reg_wdata[`CQC_BIT_SEND])
        send_ff <= 1'b1;
    end
    // Arm drop wins over any start in the same cycle
    if ((ctrl_wr && !reg_wdata[`CQC_BIT_TMR_ARM]) || !arm_ff)
      cycle_timer_run <= 1'b0;
    else if (trigger_cmd || (state_ff == ST_IDLE && nxt_state == ST_SEND))
      cycle_timer_run <= 1'b1;
    case (state_ff)
      ST_IDLE: begin
        if (est_ff || wake_ff) begin
          from_est_ff <= est_ff && !wake_ff;
          wake_cnt_ff <= WAKE_CYC - {{(CYC_W-1){1'b0}}, 1'b1};
          line_port_a_tx_en <= 1'b1;
          line_port_a_wake_drive <= 1'b1;
          current_limit_boost <= 1'b1;
          try_rate_ff <= `CQC_RATE_COM3;
        end else if (send_ff) begin
          send_ff <= 1'b0;
          line_port_a_tx_en <= 1'b1;
        end
      end
      ST_WAKE: begin
        wake_cnt_ff <= wake_cnt_ff - {{(CYC_W-1){1'b0}}, 1'b1};
        if (wake_cnt_ff == {CYC_W{1'b0}}) begin
          line_port_a_wake_drive <= 1'b0;
          current_limit_boost <= 1'b0;
          line_port_a_tx_en <= 1'b0;
          if (!from_est_ff)
            wake_ff <= 1'b0;
        end
      end
      ST_PROBE: begin
        // Rate tried fastest first; a reply at this rate ends the search
        wait_ff <= WAIT_CYC_W;
      end
      ST_LISTEN: begin
        wait_ff <= wait_ff - 32'd1;
        if (reply_seen) begin
          line_rate <= try_rate_ff;
          device_cycle_time <= device_cycle_time_in;
          est_ff <= 1'b0;
          wake_ff <= 1'b0;
          wake_sequence_irq <= 1'b1;
        end else if (wait_ff == 32'd0) begin
          if (try_rate_ff == `CQC_RATE_COM1) begin
            line_rate <= `CQC_RATE_FAIL;
            est_ff <= 1'b0;
            wake_ff <= 1'b0;
            wake_sequence_irq <= 1'b1;
          end else begin
            try_rate_ff <= try_rate_ff - 2'd1;
            est_ff <= 1'b1;
          end
        end
      end
      ST_SEND: ;
      ST_DRAIN: begin
        if (tx_byte_done)
          line_port_a_tx_en <= 1'b0;
      end
      ST_RECV: line_port_a_tx_en <= 1'b0;
      default: line_port_a_tx_en <= 1'b0;
    endcase
    if (reg_rd && reg_addr == `CQC_ADDR_CTRL_A)
      reg_rdata <= {line_rate, est_ff, wake_ff, 2'b00, arm_ff, send_ff};
    else
      reg_rdata <= 8'h00;
  end
end
endmodule // cqc_channel_ctrl

// ---- bench/cqc_ctrl_props.sv ----
// Checker for the C/Q control block, watching its ports only.
// Assumes one clock and the block's synchronous active-high reset.
`timescale 1ns/1ps
module cqc_ctrl_props #(
  parameter WAKE_NS = 80000
) (
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire trigger_cmd,
  input wire line_port_a_tx_en,
  input wire line_port_a_wake_drive,
  input wire current_limit_boost,
  input wire tx_queue_clear,
  input wire rx_queue_clear,
  input wire wake_sequence_irq,
  input wire cycle_timer_run
);
  localparam int WCYC = WAKE_NS / 10;
  logic [31:0] wcnt_ff;
  wire wr6 = reg_wr && clk_en && reg_addr == 8'h06;
  // Listen phase looks idle here too; stimulus keeps out of it
  wire idle = !line_port_a_tx_en && !line_port_a_wake_drive;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    if (reset || !line_port_a_wake_drive) wcnt_ff <= 32'h0000_0000;
    else wcnt_ff <= wcnt_ff + 32'h0000_0001;
  end
  chk_txclr_pulse: assert property (wr6 && reg_wdata[3] |=> tx_queue_clear ##1 !tx_queue_clear)
    else $error("tx clear pulse wrong");
  chk_rxclr_pulse: assert property (wr6 && reg_wdata[2] |=> rx_queue_clear ##1 !rx_queue_clear)
    else $error("rx clear pulse wrong");
  chk_wake_start: assert property (wr6 && reg_wdata[4] && idle |-> ##2 line_port_a_wake_drive)
    else $error("wake pulse late");
  chk_wake_len: assert property ($fell(line_port_a_wake_drive) |-> wcnt_ff >= WCYC && wcnt_ff <= WCYC + 1)
    else $error("wake pulse length wrong");
  chk_wake_to_rx: assert property ($fell(line_port_a_wake_drive) |-> !line_port_a_tx_en)
    else $error("no receive after wake");
  chk_boost_track: assert property (current_limit_boost == line_port_a_wake_drive)
    else $error("boost not tied to wake");
  chk_irq_once: assert property ($rose(wake_sequence_irq) |=> !wake_sequence_irq)
    else $error("irq longer than one cycle");
  chk_send_start: assert property (wr6 && reg_wdata[0] && !reg_wdata[5] && !reg_wdata[4] && idle
    |-> ##2 line_port_a_tx_en)
    else $error("send did not transmit");
  chk_timer_stop: assert property (wr6 && !reg_wdata[1] |=> !cycle_timer_run)
    else $error("timer kept running");
  chk_timer_cause: assert property ($rose(cycle_timer_run)
    |-> $rose(line_port_a_tx_en) || $past(trigger_cmd) || $past(trigger_cmd, 2))
    else $error("timer started unprompted");
endmodule // cqc_ctrl_props

bind cqc_channel_ctrl cqc_ctrl_props #(.WAKE_NS(WAKE_NS)) u_cqc_ctrl_props (.*);

// ---- bench/cqc_line_device.sv ----
// Far-side model: device start bit on the line and a UART that stalls.
// Assumes listen windows of WAIT cycles that follow the wake pulse.
`timescale 1ns/1ps
module cqc_line_device #(
  parameter WAIT = 50
) (
  input wire ref_clk,
  input wire line_port_a_wake_drive,
  input wire [1:0] reply_try,
  input wire uart_valid,
  output logic uart_ready,
  output logic tx_byte_done,
  output logic line_rx_pin
);
  int cnt;
  int at;
  logic acc;
  logic drv_d;
  initial begin
    line_rx_pin = 1'b1;
    uart_ready = 1'b0;
    tx_byte_done = 1'b0;
    cnt = -1;
    drv_d = 1'b0;
  end
  // Reply 0 stays silent; line idles high on its pull-up
  always @(posedge ref_clk) begin
    acc = uart_valid;
    at = (reply_try - 1) * WAIT + 20;
    if (drv_d && !line_port_a_wake_drive) cnt = 0;
    else if (cnt >= 0) cnt = cnt + 1;
    drv_d = line_port_a_wake_drive;
    #1;
    tx_byte_done = acc;
    uart_ready = 1'($urandom_range(1, 0));
    line_rx_pin = !(reply_try != 2'h0 && cnt >= at && cnt < at + 4);
  end
endmodule // cqc_line_device

// ---- bench/cq_channel_control_test.sv ----
// Testbench for the C/Q control block with its far-side model.
// Assumes the design's ports as declared and shortened wake and wait counts.
`timescale 1ns/1ps
module cq_channel_control_test;
  logic ref_clk, reset, clk_en, reg_wr, reg_rd, frame_handler_enable, tx_valid, tx_ready;
  logic tx_queue_empty, tx_byte_done, uart_valid, uart_ready, line_rx_pin, trigger_cmd;
  logic line_port_a_tx_en, line_port_a_wake_drive, current_limit_boost, rd_seen;
  logic tx_queue_clear, rx_queue_clear, wake_sequence_irq, cycle_timer_run;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data, uart_data;
  logic [7:0] device_cycle_time_in, device_cycle_time;
  logic [1:0] line_rate, reply_try;
  logic [7:0] rq[$], dq[$];
  logic [1:0] iq[$];
  int miscompares, checked, n, k;
  cqc_channel_ctrl #(.WAKE_NS(200), .WAIT_CYC(50)) u_cqc_channel_ctrl (.*);
  cqc_line_device #(.WAIT(50)) u_cqc_line_device (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic cyc(int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    rq.push_back(e);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
  endtask
  task automatic conclude();
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Monitor: oldest note against what appears
  always @(posedge ref_clk) begin
    if (rd_seen) chk("reg_rdata", rq.pop_front(), reg_rdata);
    if (wake_sequence_irq) chk("line_rate", {6'h00, iq.pop_front()}, {6'h00, line_rate});
    if (uart_valid) chk("uart_data", dq.pop_front(), uart_data);
    rd_seen <= reg_rd;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end
  initial begin
    {reset, clk_en, tx_queue_empty} = 3'h7;
    {reg_wr, reg_rd, frame_handler_enable, tx_valid, trigger_cmd, rd_seen} = 6'h00;
    {reg_addr, reg_wdata, tx_data, device_cycle_time_in, reply_try} = 34'h0_0000_0000;
    void'($urandom(32'h1132_e9a4));
    cyc(16);
    reset = 1'b0;
    rd(8'h06, 8'h00);
    wr(8'h06, 8'h08);
    wr(8'h06, 8'h04);
    rd(8'h06, 8'h00);
    wr(8'h07, 8'h10);
    rd(8'h07, 8'h00);
    rd(8'h06, 8'h00);
    wr(8'h06, 8'h10);
    rd(8'h06, 8'h10);
    for (n = 0; n < 99 && line_port_a_wake_drive !== 1'b0; n++) cyc(1);
    cyc(2);
    rd(8'h06, 8'h00);
    wr(8'h06, 8'h20);
    cyc(30);
    rd(8'h06, 8'h00);
    frame_handler_enable = 1'b1;
    // Reply in window 1..3 then silence: rates 3,2,1,0
    for (k = 0; k < 4; k++) begin
      reply_try = 2'(k == 3 ? 0 : k + 1);
      iq.push_back(2'(3 - k));
      device_cycle_time_in = 8'($urandom);
      wr(8'h06, 8'h20);
      for (n = 0; n < 400 && wake_sequence_irq !== 1'b1; n++) cyc(1);
      cyc(2);
      rd(8'h06, {2'(3 - k), 6'h00});
      if (k < 3) chk("cycle time", device_cycle_time_in, device_cycle_time);
    end
    wr(8'h06, 8'h02);
    chk("timer run", 8'h00, {7'h00, cycle_timer_run});
    tx_queue_empty = 1'b0;
    for (n = 0; n < 4 && tx_ready === 1'b1; n++) begin
      tx_data = 8'($urandom);
      tx_valid = 1'b1;
      dq.push_back(tx_data);
      cyc(1);
    end
    tx_valid = 1'b0;
    chk("buffer fill", 8'h02, 8'(n));
    tx_queue_empty = 1'b1;
    wr(8'h06, 8'h03);
    cyc(1);
    chk("tx enable", 8'h01, {7'h00, line_port_a_tx_en});
    chk("timer run", 8'h01, {7'h00, cycle_timer_run});
    rd(8'h06, 8'h02);
    for (n = 0; n < 300 && line_port_a_tx_en !== 1'b0; n++) cyc(1);
    chk("bytes left", 8'h00, 8'(dq.size()));
    wr(8'h06, 8'h00);
    chk("timer run", 8'h00, {7'h00, cycle_timer_run});
    wr(8'h06, 8'h02);
    trigger_cmd = 1'b1;
    cyc(1);
    trigger_cmd = 1'b0;
    cyc(1);
    chk("timer run", 8'h01, {7'h00, cycle_timer_run});
    wr(8'h06, 8'h00);
    chk("timer run", 8'h00, {7'h00, cycle_timer_run});
    conclude();
  end
endmodule // cq_channel_control_test
